// [design/iparb_arbiter.sv]
// Interrupt acknowledge arbitration: level decode, contention, vector and
// external hand-off. Assumes requesters and the core run on core_clk;
// external termination arrives on a pin from outside the clock domain.
// Behaviour
// - Latch acknowledged level and mask interrupts at or below that level while processing.
// - Requesters take part only when their pending level equals acknowledged level.
// - Same-level requests resolved by bit-serial contention of arbitration fields.
// - Each requester, system unit included, holds a 4-bit field, 1 low to 15 high.
// - A recognised requester with field zero yields a spurious exception.
// - The system unit's field stands for all external requests.
// - Reset loads 15 into the system unit field, zero into the others.
// - Contention runs on every acknowledge, even with one requester.
// - External acknowledge cycle runs only when the system unit wins.
// - No contender: bus error ends the cycle, spurious exception follows.
// - The winner supplies the vector number and ends the cycle.
// - External device answering too late yields a spurious exception.
// - Timer requests win over external requests of the same level.
// - Acknowledge drives function code 7, ones around the level on address.
`timescale 1ns/1ps
`default_nettype none
`include "iparb_params.svh"

module iparb_arbiter #(
	parameter int NUM_MODULES    = `IPARB_NUM_MODULES,
	parameter int TIMEOUT_CYCLES = `IPARB_ACK_TIMEOUT_CYC
) (
	// Clock and reset
	input  wire logic                                        core_clk,
	input  wire logic                                        rst,
	// Acknowledge request from the core
	input  wire logic                                        ackStart,
	input  wire logic [`IPARB_LEVEL_W-1:0]                   ackLevel,
	// Acknowledge cycle outputs
	output var  iparb_pkg::iparb_ack_bus_t                   ackBus,
	output logic                                             cycleActive,
	output logic                                             ackDone,
	output logic [`IPARB_VECTOR_W-1:0]                       ackVector,
	output logic                                             spurious,
	output logic                                             busError,
	// Masking toward the core
	output logic [`IPARB_LEVEL_W-1:0]                        maskLevel,
	output logic                                             coreIrq,
	// Requesting modules, index 0 is the system unit
	input  wire logic [NUM_MODULES-1:0][`IPARB_LEVEL_W-1:0]  reqLevel,
	input  wire logic [NUM_MODULES-1:0][`IPARB_VECTOR_W-1:0] reqVector,
	input  wire logic [`IPARB_LEVEL_W-1:0]                   timerLevel,
	input  wire logic [`IPARB_VECTOR_W-1:0]                  timerVector,
	// Arbitration field configuration
	input  wire iparb_pkg::iparb_cfg_wr_t                    cfgWr,
	output logic [NUM_MODULES-1:0][`IPARB_FIELD_W-1:0]       arbField,
	// External bus
	output logic                                             extCycle,
	input  wire logic                                        extTermPin,
	input  wire logic [`IPARB_VECTOR_W-1:0]                  extDataPin
);
	import iparb_pkg::*;

	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
	localparam int IW = (NUM_MODULES > 1) ? $clog2(NUM_MODULES) : 1;
	localparam logic [NUM_MODULES-1:0][`IPARB_FIELD_W-1:0] FIELD_RST =
		{{(NUM_MODULES - 1){`IPARB_FIELD_OTHER_RST}}, `IPARB_FIELD_SIU_RST};

	typedef struct packed {
		iparb_phase_t                              phase;
		logic [`IPARB_LEVEL_W-1:0]                 level;
		logic [`IPARB_LEVEL_W-1:0]                 mask;
		logic [NUM_MODULES-1:0][`IPARB_FIELD_W-1:0] field;
		logic [2:0]                                termSync;
		logic [TW-1:0]                             timer;
		logic [`IPARB_VECTOR_W-1:0]                vector;
		logic                                      start;
		logic                                      done;
		logic                                      spur;
		logic                                      berr;
		logic                                      ext;
		iparb_ack_bus_t                            bus;
	} iparb_core_t;

	iparb_core_t st;
	iparb_core_t next_st;
	logic [NUM_MODULES-1:0] active;
	logic [NUM_MODULES-1:0] arbWinner;
	logic                   arbDone;
	logic [IW-1:0]          winIdx;
	logic                   termSeen;
	logic                   timerHit;
	logic [`IPARB_LEVEL_W-1:0] pendMax;

	// Pending request matches the acknowledged level
	function automatic logic levelMatch(input logic [`IPARB_LEVEL_W-1:0] req,
			input logic [`IPARB_LEVEL_W-1:0] lvl);
		levelMatch = (req != `IPARB_NO_REQUEST) && (req == lvl);
	endfunction

	// Lowest index among equal winners
	function automatic logic [IW-1:0] firstWinner(input logic [NUM_MODULES-1:0] w);
		firstWinner = '0;
		for (int m = NUM_MODULES - 1; m >= 0; m--) begin
			if (w[m]) begin
				firstWinner = IW'(m);
			end
		end
	endfunction

	assign timerHit = levelMatch(timerLevel, st.level);

	// Contender set for the acknowledged level
	for (genvar m = 0; m < NUM_MODULES; m++) begin : g_active
		if (m == `IPARB_SIU_INDEX) begin : g_siu
			assign active[m] = levelMatch(reqLevel[m], st.level) || timerHit;
		end else begin : g_mod
			assign active[m] = levelMatch(reqLevel[m], st.level);
		end
	end

	iparb_contend #(
		.NUM_MODULES (NUM_MODULES)
	) u_contend (
		.core_clk (core_clk),
		.rst      (rst),
		.start    (st.start),
		.active   (active),
		.field    (st.field),
		.done     (arbDone),
		.winner   (arbWinner)
	);

	assign winIdx = firstWinner(arbWinner);
	assign termSeen = st.termSync[1] & st.termSync[2];

	always_comb begin
		next_st = st;
		next_st.start = 1'b0;
		next_st.done = 1'b0;
		next_st.spur = 1'b0;
		next_st.berr = 1'b0;
		next_st.termSync = {st.termSync[1:0], extTermPin};
		if (cfgWr.en && int'(cfgWr.idx) < NUM_MODULES) begin
			next_st.field[cfgWr.idx] = cfgWr.field;
		end
		unique case (st.phase)
			IPARB_IDLE: begin
				if (ackStart) begin
					next_st.phase = IPARB_ARB;
					next_st.level = ackLevel;
					next_st.mask = ackLevel;
					next_st.start = 1'b1;
					next_st.bus.fc = `IPARB_FC_CPU_SPACE;
					next_st.bus.addr = {`IPARB_ADDR_IACK_HI, ackLevel, `IPARB_ADDR_IACK_LSB};
				end
			end
			IPARB_ARB: begin
				if (arbDone) begin
					next_st.phase = IPARB_IDLE;
					if (arbWinner == '0) begin
						next_st.berr = 1'b1;
						next_st.spur = 1'b1;
					end else if (st.field[winIdx] == `IPARB_FIELD_SPURIOUS) begin
						next_st.spur = 1'b1;
					end else if (int'(winIdx) != `IPARB_SIU_INDEX) begin
						next_st.vector = reqVector[winIdx];
						next_st.done = 1'b1;
					end else if (timerHit) begin
						next_st.vector = timerVector;
						next_st.done = 1'b1;
					end else begin
						next_st.phase = IPARB_EXT;
						next_st.ext = 1'b1;
						next_st.timer = TW'(TIMEOUT_CYCLES);
					end
				end
			end
			IPARB_EXT: begin
				if (termSeen) begin
					next_st.vector = extDataPin;
					next_st.done = 1'b1;
					next_st.ext = 1'b0;
					next_st.phase = IPARB_IDLE;
				end else if (st.timer <= TW'(1)) begin
					next_st.spur = 1'b1;
					next_st.ext = 1'b0;
					next_st.phase = IPARB_IDLE;
				end else begin
					next_st.timer = st.timer - TW'(1);
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
			st.phase <= IPARB_IDLE;
			st.field <= FIELD_RST;
			st.mask <= `IPARB_MASK_RST;
		end else begin
			st <= next_st;
		end
	end

	// Highest pending level against the latched mask
	always_comb begin
		pendMax = timerLevel;
		for (int m = 0; m < NUM_MODULES; m++) begin
			if (reqLevel[m] > pendMax) begin
				pendMax = reqLevel[m];
			end
		end
	end
	assign coreIrq = pendMax > st.mask;

	assign ackBus = st.bus;
	assign cycleActive = st.phase != IPARB_IDLE;
	assign ackDone = st.done;
	assign ackVector = st.vector;
	assign spurious = st.spur;
	assign busError = st.berr;
	assign maskLevel = st.mask;
	assign arbField = st.field;
	assign extCycle = st.ext;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_siu_wins;
		arbDone && st.phase == IPARB_ARB && arbWinner != '0 && int'(winIdx) == 0
			&& st.field[0] != `IPARB_FIELD_SPURIOUS;
	endsequence
	sequence s_ext_open;
		extCycle && !termSeen;
	endsequence

	property p_mask_latch;
		st.phase == IPARB_IDLE && ackStart |=> maskLevel == $past(ackLevel)
			&& coreIrq == (pendMax > $past(ackLevel));
	endproperty
	a_mask_latch: assert property (p_mask_latch) else $error("mask not latched");

	property p_ack_bus;
		cycleActive |-> ackBus.fc == `IPARB_FC_CPU_SPACE
			&& ackBus.addr == {`IPARB_ADDR_IACK_HI, st.level, `IPARB_ADDR_IACK_LSB};
	endproperty
	a_ack_bus: assert property (p_ack_bus) else $error("acknowledge address wrong");

	property p_field_reset;
		disable iff (1'b0) rst |=> arbField == FIELD_RST;
	endproperty
	a_field_reset: assert property (p_field_reset) else $error("field reset wrong");

	property p_always_contend;
		st.phase == IPARB_IDLE && ackStart |-> ##6 arbDone;
	endproperty
	a_always_contend: assert property (p_always_contend) else $error("no contention");

	property p_ext_only_siu;
		$rose(extCycle) |-> $past(arbDone && arbWinner[0] && !timerHit);
	endproperty
	a_ext_only_siu: assert property (p_ext_only_siu) else $error("external without win");

	property p_none_berr;
		arbDone && st.phase == IPARB_ARB && arbWinner == '0 |=> busError && spurious
			&& !ackDone && !cycleActive;
	endproperty
	a_none_berr: assert property (p_none_berr) else $error("no bus error");

	property p_winner_vector;
		arbDone && st.phase == IPARB_ARB && int'(winIdx) != 0
			&& st.field[winIdx] != `IPARB_FIELD_SPURIOUS
			|=> ackDone && ackVector == $past(reqVector[winIdx]);
	endproperty
	a_winner_vector: assert property (p_winner_vector) else $error("wrong vector");

	property p_zero_field;
		arbDone && st.phase == IPARB_ARB && arbWinner != '0
			&& st.field[winIdx] == `IPARB_FIELD_SPURIOUS |=> spurious && !ackDone;
	endproperty
	a_zero_field: assert property (p_zero_field) else $error("zero field not spurious");

	property p_timer_first;
		s_siu_wins and timerHit |=> ackDone && ackVector == $past(timerVector) && !extCycle;
	endproperty
	a_timer_first: assert property (p_timer_first) else $error("timer not first");

	property p_timeout;
		s_ext_open and (st.timer == TW'(1)) |=> spurious && !extCycle && !ackDone;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout not spurious");

	property p_ext_answer;
		s_ext_open ##1 (extCycle && termSeen) |=> ackDone && ackVector == $past(extDataPin);
	endproperty
	a_ext_answer: assert property (p_ext_answer) else $error("external vector lost");

endmodule

`default_nettype wire

// [shared/iparb_params.svh]
// Constants of the interrupt acknowledge arbitration block.
// Assumes inclusion by its bare name from the package and design files.
`ifndef IPARB_PARAMS_SVH
`define IPARB_PARAMS_SVH

// Sizes
`define IPARB_NUM_MODULES      4
`define IPARB_LEVEL_W          3
`define IPARB_FIELD_W          4
`define IPARB_VECTOR_W         8
`define IPARB_ADDR_W           24
`define IPARB_ADDR_HI_W        20
`define IPARB_FC_W             3
`define IPARB_CFG_IDX_W        4

// Acknowledge cycle encoding
`define IPARB_FC_CPU_SPACE     3'h7
`define IPARB_ADDR_IACK_HI     20'hF_FFFF
`define IPARB_ADDR_IACK_LSB    1'h1

// Arbitration field values
`define IPARB_FIELD_SIU_RST    4'hF
`define IPARB_FIELD_OTHER_RST  4'h0
`define IPARB_FIELD_SPURIOUS   4'h0
`define IPARB_SIU_INDEX        0

// Levels
`define IPARB_NO_REQUEST       3'h0
`define IPARB_MASK_RST         3'h7

// Timing
`define IPARB_CLK_PERIOD_NS    10
`define IPARB_ACK_TIMEOUT_NS   1280
`define IPARB_ACK_TIMEOUT_CYC  (`IPARB_ACK_TIMEOUT_NS / `IPARB_CLK_PERIOD_NS)
`define IPARB_CONTEND_STEPS    4

`endif

// [shared/iparb_pkg.sv]
// Types shared by the arbitration block and its surroundings.
// Assumes the constants header is on the include path.
`include "iparb_params.svh"

package iparb_pkg;

	typedef enum logic [1:0] {
		IPARB_IDLE,
		IPARB_ARB,
		IPARB_EXT
	} iparb_phase_t;

	// Address side of the acknowledge cycle
	typedef struct packed {
		logic [`IPARB_FC_W-1:0]   fc;
		logic [`IPARB_ADDR_W-1:0] addr;
	} iparb_ack_bus_t;

	// Arbitration field write from configuration logic
	typedef struct packed {
		logic                       en;
		logic [`IPARB_CFG_IDX_W-1:0] idx;
		logic [`IPARB_FIELD_W-1:0]   field;
	} iparb_cfg_wr_t;

endpackage

// [design/iparb_contend.sv]
// Bit-serial contention among arbitration fields, most significant bit first.
// Assumes start is a one-cycle pulse from logic on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "iparb_params.svh"

module iparb_contend #(
	parameter int NUM_MODULES = `IPARB_NUM_MODULES
) (
	// Clock and reset
	input  wire logic                                      core_clk,
	input  wire logic                                      rst,
	// Contention request
	input  wire logic                                      start,
	input  wire logic [NUM_MODULES-1:0]                    active,
	input  wire logic [NUM_MODULES-1:0][`IPARB_FIELD_W-1:0] field,
	// Result
	output logic                                           done,
	output logic [NUM_MODULES-1:0]                         winner
);
	import iparb_pkg::*;

	typedef struct packed {
		logic [NUM_MODULES-1:0] alive;
		logic [1:0]             bitIdx;
		logic                   busy;
		logic                   done;
		logic [NUM_MODULES-1:0] winner;
	} iparb_cont_t;

	iparb_cont_t st;
	iparb_cont_t next_st;
	logic [`IPARB_FIELD_W-1:0][NUM_MODULES-1:0] column;
	logic [NUM_MODULES-1:0] stepBits;
	logic [NUM_MODULES-1:0] survivors;

	// Bit columns of all fields
	for (genvar b = 0; b < `IPARB_FIELD_W; b++) begin : g_col
		for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
			assign column[b][m] = field[m][b];
		end
	end

	// A one on the wired line knocks out every zero
	assign stepBits = st.alive & column[st.bitIdx];
	assign survivors = (|stepBits) ? stepBits : st.alive;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (start && !st.busy) begin
			next_st.alive = active;
			next_st.bitIdx = 2'(`IPARB_FIELD_W - 1);
			next_st.busy = 1'b1;
		end else if (st.busy) begin
			next_st.alive = survivors;
			next_st.bitIdx = st.bitIdx - 2'h1;
			if (st.bitIdx == 2'h0) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
				next_st.winner = survivors;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign done = st.done;
	assign winner = st.winner;

	// Helper: largest field among the contenders, caught at start
	logic [`IPARB_FIELD_W-1:0] maxAtStart;
	logic [`IPARB_FIELD_W-1:0] maxNow;
	logic                      winnersOk;
	always_comb begin
		maxNow = '0;
		winnersOk = 1'b1;
		for (int m = 0; m < NUM_MODULES; m++) begin
			if (active[m] && field[m] > maxNow) begin
				maxNow = field[m];
			end
			if (st.winner[m] && field[m] != maxAtStart) begin
				winnersOk = 1'b0;
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			maxAtStart <= '0;
		end else if (start && !st.busy) begin
			maxAtStart <= maxNow;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_serial_len;
		start && !st.busy |-> !done [*5] ##1 done;
	endproperty
	a_serial_len: assert property (p_serial_len) else $error("contention not four steps");

	property p_largest_wins;
		done && (|winner) |-> winnersOk;
	endproperty
	a_largest_wins: assert property (p_largest_wins) else $error("smaller field won");

	property p_none_empty;
		start && !st.busy && active == '0 |-> ##5 (done && winner == '0);
	endproperty
	a_none_empty: assert property (p_none_empty) else $error("winner from no contender");

endmodule

`default_nettype wire

// [tb/iparb_ext_device.sv]
// Model of an external interrupting device on the external bus.
// Assumes the arbiter's acknowledge bus and external cycle flag on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "iparb_params.svh"

module iparb_ext_device
	import iparb_pkg::*;
(
	// Clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         rst,
	// Acknowledge cycle seen on the bus
	input  wire iparb_pkg::iparb_ack_bus_t    ackBus,
	input  wire logic                         extCycle,
	// Device setup from the bench
	input  wire logic [`IPARB_LEVEL_W-1:0]    level,
	input  wire logic [7:0]                   delay,
	input  wire logic [`IPARB_VECTOR_W-1:0]   vector,
	// Pins toward the arbiter
	output logic                              extTermPin,
	output logic [`IPARB_VECTOR_W-1:0]        extDataPin
);
	logic [7:0] cnt;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt        <= 8'h00;
			extTermPin <= 1'b0;
			extDataPin <= 8'hA5;
		end else if (!extCycle) begin
			// Released data lines keep moving
			cnt        <= 8'h00;
			extTermPin <= 1'b0;
			extDataPin <= ~extDataPin;
		end else if (ackBus.fc == 3'h7 && ackBus.addr[3:1] == level) begin
			cnt <= cnt + 8'h01;
			if (cnt + 8'h01 == delay) begin
				extTermPin <= 1'b1;
				extDataPin <= vector;
			end
		end
	end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the acknowledge arbiter.
// Assumes the arbiter with a short acknowledge timeout and one external device.
`timescale 1ns/1ps
`default_nettype none
`include "iparb_params.svh"

module tb;
	import iparb_pkg::*;
	localparam int N = 4;
	localparam int TMO = 8;
	// Falling edges counted from the taking edge until the answer shows
	localparam int ANS_LAT = 7;

	logic                  core_clk = 1'b0;
	logic                  rst = 1'b1;
	logic                  ackStart = 1'b0;
	logic [2:0]            ackLevel = 3'h0;
	iparb_ack_bus_t        ackBus;
	logic                  cycleActive, ackDone, spurious, busError, coreIrq, extCycle;
	logic [7:0]            ackVector;
	logic [2:0]            maskLevel;
	logic [N-1:0][2:0]     reqLevel = '0;
	logic [N-1:0][7:0]     reqVector = {8'h43, 8'h42, 8'h41, 8'h40};
	logic [2:0]            timerLevel = 3'h0;
	logic [7:0]            timerVector = 8'h77;
	iparb_cfg_wr_t         cfgWr = '0;
	logic [N-1:0][3:0]     arbField;
	logic                  extTermPin;
	logic [7:0]            extDataPin;
	logic [2:0]            devLevel = 3'h2;
	logic [7:0]            devDelay = 8'h03;
	int                    errors = 0;
	int                    check_count = 0;
	int                    lat;

	always #5 core_clk = ~core_clk;

	iparb_arbiter #(.NUM_MODULES(N), .TIMEOUT_CYCLES(TMO)) dut (
		.core_clk(core_clk), .rst(rst), .ackStart(ackStart), .ackLevel(ackLevel),
		.ackBus(ackBus), .cycleActive(cycleActive), .ackDone(ackDone),
		.ackVector(ackVector), .spurious(spurious), .busError(busError),
		.maskLevel(maskLevel), .coreIrq(coreIrq), .reqLevel(reqLevel),
		.reqVector(reqVector), .timerLevel(timerLevel), .timerVector(timerVector),
		.cfgWr(cfgWr), .arbField(arbField), .extCycle(extCycle),
		.extTermPin(extTermPin), .extDataPin(extDataPin));

	iparb_ext_device ext (
		.core_clk(core_clk), .rst(rst), .ackBus(ackBus), .extCycle(extCycle),
		.level(devLevel), .delay(devDelay), .vector(8'h5A),
		.extTermPin(extTermPin), .extDataPin(extDataPin));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic set_field(input logic [3:0] idx, input logic [3:0] f);
		cfgWr = '{en: 1'b1, idx: idx, field: f};
		@(negedge core_clk);
		cfgWr.en = 1'b0;
		@(negedge core_clk);
	endtask

	// Runs one acknowledge; returns edges until an answer shows
	task automatic do_ack(input logic [2:0] lvl, output int n);
		ackStart = 1'b1;
		ackLevel = lvl;
		@(negedge core_clk);
		ackStart = 1'b0;
		check("cycleActive", cycleActive, 1'b1);
		check("ackBus", 32'(ackBus), {5'h0, 3'h7, 20'hF_FFFF, lvl, 1'b1});
		check("maskLevel", maskLevel, lvl);
		n = 1;
		while (n < 40 && !(ackDone || spurious || extCycle)) begin
			@(negedge core_clk);
			n++;
		end
	endtask

	task automatic t_reset();
		check("arbField", arbField, {4'h0, 4'h0, 4'h0, 4'hF});
		check("maskLevel", maskLevel, 3'h7);
		check("ackBus", 32'(ackBus), 32'h0000_0000);
		check("idle", {cycleActive, extCycle, ackDone, spurious}, 4'h0);
		$display("test reset done");
	endtask

	task automatic t_cfg();
		set_field(4'h1, 4'h3);
		set_field(4'h2, 4'h9);
		set_field(4'h3, 4'h5);
		set_field(4'h4, 4'hE);
		check("arbField", arbField, {4'h5, 4'h9, 4'h3, 4'hF});
		$display("test config done");
	endtask

	task automatic t_single();
		reqLevel = '0;
		reqLevel[1] = 3'h3;
		do_ack(3'h3, lat);
		check("latency", lat, ANS_LAT);
		check("done", {ackDone, spurious, extCycle}, 3'h4);
		check("vector", ackVector, 8'h41);
		check("irq masked", coreIrq, 1'b0);
		reqLevel[3] = 3'h5;
		@(negedge core_clk);
		check("irq above mask", coreIrq, 1'b1);
		$display("test single done");
	endtask

	task automatic t_contend();
		reqLevel = {3'h4, 3'h4, 3'h4, 3'h0};
		do_ack(3'h4, lat);
		check("latency", lat, ANS_LAT);
		check("vector", ackVector, 8'h42);
		check("no ext", extCycle, 1'b0);
		@(negedge core_clk);
		reqLevel[2] = 3'h5;
		do_ack(3'h4, lat);
		check("vector", ackVector, 8'h43);
		$display("test contention done");
	endtask

	task automatic t_none();
		reqLevel = {3'h4, 3'h0, 3'h0, 3'h0};
		do_ack(3'h6, lat);
		check("latency", lat, ANS_LAT);
		check("bus error", {busError, spurious, ackDone}, 3'h6);
		$display("test no contender done");
	endtask

	task automatic t_zero();
		set_field(4'h1, 4'h0);
		reqLevel = {3'h0, 3'h0, 3'h2, 3'h0};
		do_ack(3'h2, lat);
		check("zero field", {busError, spurious, ackDone}, 3'h2);
		set_field(4'h1, 4'h3);
		$display("test zero field done");
	endtask

	task automatic t_ext(input logic [2:0] dLvl);
		int k;
		devLevel = dLvl;
		reqLevel = {3'h2, 3'h0, 3'h0, 3'h2};
		do_ack(3'h2, lat);
		check("latency", lat, ANS_LAT);
		check("ext won", {extCycle, ackDone, spurious}, 3'h4);
		k = 0;
		while (k < TMO + 20 && !(ackDone || spurious)) begin
			@(negedge core_clk);
			k++;
		end
		if (dLvl == 3'h2) begin
			check("ext done", {ackDone, spurious, ackVector}, {2'b10, 8'h5A});
			check("ext quick", k <= 8, 1'b1);
		end else begin
			check("late answer", {spurious, ackDone, busError}, 3'h4);
			check("timeout", k >= TMO - 1 && k <= TMO + 1, 1'b1);
		end
		@(negedge core_clk);
		check("ext over", extCycle, 1'b0);
		repeat (4) @(negedge core_clk);
		$display("test external done");
	endtask

	task automatic t_timer();
		reqLevel = {3'h0, 3'h0, 3'h0, 3'h2};
		timerLevel = 3'h2;
		do_ack(3'h2, lat);
		check("timer first", {ackDone, extCycle, ackVector}, {2'b10, 8'h77});
		timerLevel = 3'h0;
		$display("test timer done");
	endtask

	initial begin
		#200000;
		errors++;
		give_verdict();
	end

	initial begin
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
		@(negedge core_clk);
		t_reset();
		t_cfg();
		t_single();
		t_contend();
		t_none();
		t_zero();
		t_ext(3'h2);
		t_ext(3'h3);
		t_timer();
		give_verdict();
	end
endmodule
`default_nettype wire
